// [src/rsr_rx_status.sv]
// Receive status register bank: per-packet results and live
// direction-finding state, read over a plain strobe port.
// Assumes the radio pulses RX_DONE once per finished reception
// with RX_RESULT valid in that cycle.
//
// The plain strobed port was chosen for this implementation.
`default_nettype none

module rsr_rx_status #(
  parameter int ADDR_WIDTH = rsr_pkg::ADDR_W
) (
  input  wire logic                       SYS_CLK,
  input  wire logic                       SYS_RST,
  input  wire rsr_pkg::rsr_bus_req_type   BUS_REQ,
  output var  logic [31:0]                BUS_RDATA,
  input  wire logic                       RX_DONE,
  input  wire rsr_pkg::rsr_rx_result_type RX_RESULT,
  input  wire rsr_pkg::rsr_df_state_type  DF_STATE,
  output var  logic                       IRQ
);

  import rsr_pkg::*;

  // Refuse an address width that the fixed map cannot serve
  if (ADDR_WIDTH != ADDR_W) begin : g_bad_addr
    $error("ADDR_WIDTH must match the register map");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  rsr_rx_result_type rx_reg;
  rsr_rx_result_type rx_next;
  rsr_df_state_type  df_reg;
  logic [31:0]       rdata_reg;
  logic [31:0]       rdata_next;
  logic [EVT_N-1:0]  evt_set;
  logic [EVT_N-1:0]  evt_status;
  logic [EVT_N-1:0]  evt_enable;
  logic              evt_irq;
  logic              clr_wr;
  logic              en_wr;

  // Address match used by both the read and the write decode
  function automatic logic hit(input logic [11:0] a,
                               input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // ----------------------------------------------------------------
  // Per-packet capture
  // ----------------------------------------------------------------

  // New results load only at reception end; otherwise hold
  always_comb begin
    rx_next = rx_reg;
    if (RX_DONE) begin
      rx_next = RX_RESULT; // RULE8
    end
  end

  // Zero after reset so software sees a failed, empty packet
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      rx_reg <= '0;
    end else begin
      rx_reg <= rx_next; // RULE8
    end
  end

  // ----------------------------------------------------------------
  // Direction-finding state mirror
  // ----------------------------------------------------------------

  // Sampled every cycle; one cycle behind the engine
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      df_reg <= '{antenna_switch_state: SW_IDLE,
                  sample_capture_state: 1'b0};
    end else begin
      df_reg <= DF_STATE; // RULE6 RULE7
    end
  end

  // ----------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------

  // A failed CRC also counts as a completed reception
  always_comb begin
    evt_set               = '0;
    evt_set[EVT_RX_DONE]  = RX_DONE;
    evt_set[EVT_CRC_FAIL] = RX_DONE && !RX_RESULT.crc_passed;
  end

  assign clr_wr = BUS_REQ.wr && hit(BUS_REQ.addr, OFS_EVT_CLR);
  assign en_wr  = BUS_REQ.wr && hit(BUS_REQ.addr, OFS_EVT_EN);

  rsr_event_flags #(
    .N (EVT_N)
  ) u_events (
    .clk        (SYS_CLK),
    .rst        (SYS_RST),
    .set_evt    (evt_set),
    .clr_wr     (clr_wr),
    .en_wr      (en_wr),
    .wdata      (BUS_REQ.wdata[EVT_N-1:0]),
    .status_reg (evt_status),
    .enable_reg (evt_enable),
    .irq_reg    (evt_irq)
  );

  assign IRQ = evt_irq;

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------

  // Unmapped and write-only addresses read as zero
  always_comb begin
    rdata_next = RESET_WORD;
    if (BUS_REQ.rd) begin
      case (1'b1)
        hit(BUS_REQ.addr, OFS_CRC_RES): begin
          rdata_next[0] = rx_reg.crc_passed; // RULE1
        end
        hit(BUS_REQ.addr, OFS_LADDR): begin
          rdata_next[2:0] = rx_reg.logical_address; // RULE2
        end
        hit(BUS_REQ.addr, OFS_RECEIVED_CRC_VALUE): begin
          rdata_next[23:0] = rx_reg.crc_value; // RULE3
        end
        hit(BUS_REQ.addr, OFS_DAI): begin
          rdata_next[2:0] = rx_reg.match_index; // RULE4
        end
        hit(BUS_REQ.addr, OFS_PSTAT): begin
          rdata_next[1:0] = rx_reg.payload_status;
        end
        hit(BUS_REQ.addr, OFS_TE_INFO): begin
          rdata_next[TE_DUR_LSB +: 5] =
            rx_reg.te_header.tone_extension_duration; // RULE5
          rdata_next[TE_RSV_BIT] =
            rx_reg.te_header.reserved_bit; // RULE5
          rdata_next[TE_TYPE_LSB +: 2] =
            rx_reg.te_header.tone_extension_type; // RULE5
        end
        hit(BUS_REQ.addr, OFS_DF_STATE): begin
          rdata_next[2:0] = df_reg.antenna_switch_state; // RULE6
          rdata_next[DF_SAMP_BIT] =
            df_reg.sample_capture_state; // RULE7
        end
        hit(BUS_REQ.addr, OFS_EVT_STAT): begin
          rdata_next[EVT_N-1:0] = evt_status;
        end
        hit(BUS_REQ.addr, OFS_EVT_EN): begin
          rdata_next[EVT_N-1:0] = evt_enable;
        end
        default: begin
          rdata_next = RESET_WORD;
        end
      endcase
    end
  end

  // Data stands only in the cycle after the strobe
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      rdata_reg <= RESET_WORD;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign BUS_RDATA = rdata_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SYS_RST);

  crc_bit_read_a: assert property ( // RULE1
    BUS_REQ.rd && BUS_REQ.addr == OFS_CRC_RES |=>
      BUS_RDATA == {31'h0, $past(rx_reg.crc_passed)})
    else $error("CRC result read word wrong");

  crc_fail_evt_a: assert property ( // RULE1
    RX_DONE && !RX_RESULT.crc_passed |=>
      evt_status[EVT_CRC_FAIL] && !rx_reg.crc_passed)
    else $error("CRC failure not recorded");

  laddr_cap_a: assert property ( // RULE2
    RX_DONE |=> rx_reg.logical_address ==
      $past(RX_RESULT.logical_address))
    else $error("Logical address not captured");

  received_crc_value_read_a: assert property ( // RULE3
    RX_DONE ##1 (BUS_REQ.rd && BUS_REQ.addr == OFS_RECEIVED_CRC_VALUE &&
      !RX_DONE) |=>
      BUS_RDATA == {8'h0, $past(RX_RESULT.crc_value, 2)})
    else $error("Received CRC read word wrong");

  dai_read_a: assert property ( // RULE4
    BUS_REQ.rd && BUS_REQ.addr == OFS_DAI |=>
      BUS_RDATA[31:3] == 29'h0 &&
      BUS_RDATA[2:0] == $past(rx_reg.match_index))
    else $error("Match index read word wrong");

  te_layout_a: assert property ( // RULE5
    BUS_REQ.rd && BUS_REQ.addr == OFS_TE_INFO |=>
      BUS_RDATA == {24'h0, $past(rx_reg.te_header)})
    else $error("Tone extension layout wrong");

  sw_state_a: assert property ( // RULE6
    BUS_REQ.rd && BUS_REQ.addr == OFS_DF_STATE |=>
      BUS_RDATA[2:0] == $past(DF_STATE.antenna_switch_state, 2))
    else $error("Switch state code wrong");

  samp_state_a: assert property ( // RULE7
    BUS_REQ.rd && BUS_REQ.addr == OFS_DF_STATE |=>
      BUS_RDATA[DF_SAMP_BIT] ==
        $past(DF_STATE.sample_capture_state, 2) &&
      BUS_RDATA[31:4] == 28'h0)
    else $error("Sampling state bit wrong");

  hold_rx_a: assert property ( // RULE8
    !RX_DONE [*2] |=> $stable(rx_reg))
    else $error("Packet fields changed without reception");

  reset_zero_a: assert property ( // RULE8
    $past(SYS_RST) |-> rx_reg == '0 && BUS_RDATA == 32'h0)
    else $error("Fields not zero after reset");

  rdata_once_a: assert property (
    !BUS_REQ.rd |=> BUS_RDATA == 32'h0)
    else $error("Read data outside its cycle");

  irq_level_a: assert property (
    |(evt_status & evt_enable) |=> IRQ)
    else $error("Enabled event raised no interrupt");

  // ----------------------------------------------------------------
  // Assertions: capture of the CRC, match index and tone extension fields, write protection and the DF mirror
  // ----------------------------------------------------------------

  // Each field must follow its own bits of the result word
  crc_pass_cap_a: assert property ( // RULE1
    RX_DONE |=> rx_reg.crc_passed == $past(RX_RESULT.crc_passed))
    else $error("CRC result bit not captured");

  crc_cap_a: assert property ( // RULE3
    RX_DONE |=> rx_reg.crc_value == $past(RX_RESULT.crc_value))
    else $error("Received CRC not captured");

  dai_cap_a: assert property ( // RULE4
    RX_DONE |=> rx_reg.match_index == $past(RX_RESULT.match_index))
    else $error("Match index not captured");

  te_cap_a: assert property ( // RULE5
    RX_DONE |=> rx_reg.te_header == $past(RX_RESULT.te_header))
    else $error("Tone extension header not captured");

  // Software writes must never reach the packet fields
  ro_write_a: assert property ( // RULE8
    BUS_REQ.wr && !RX_DONE |=> $stable(rx_reg))
    else $error("Write changed a read-only field");

  // The mirror follows the engine whenever reset is low
  df_mirror_a: assert property ( // RULE6 RULE7
    !SYS_RST |=> df_reg == $past(DF_STATE))
    else $error("Direction-finding mirror lags");

  // ----------------------------------------------------------------
  // Assertions: read words
  // ----------------------------------------------------------------

  // Reads see the bank as it stood in the strobe cycle
  laddr_read_a: assert property ( // RULE2
    BUS_REQ.rd && BUS_REQ.addr == OFS_LADDR |=>
      BUS_RDATA == {29'h0, $past(rx_reg.logical_address)})
    else $error("Logical address read word wrong");

  received_crc_value_word_a: assert property ( // RULE3
    BUS_REQ.rd && BUS_REQ.addr == OFS_RECEIVED_CRC_VALUE |=>
      BUS_RDATA == {8'h0, $past(rx_reg.crc_value)})
    else $error("Received CRC word wrong");

  pstat_read_a: assert property (
    BUS_REQ.rd && BUS_REQ.addr == OFS_PSTAT |=>
      BUS_RDATA == {30'h0, $past(rx_reg.payload_status)})
    else $error("Payload status read word wrong");

  // A write-only register must never leak its last write
  clr_read_a: assert property (
    BUS_REQ.rd && BUS_REQ.addr == OFS_EVT_CLR |=> BUS_RDATA == 32'h0)
    else $error("Clear register read nonzero");

  evt_read_a: assert property (
    BUS_REQ.rd && BUS_REQ.addr == OFS_EVT_STAT |=>
      BUS_RDATA == {30'h0, $past(evt_status)})
    else $error("Event status read word wrong");

  en_read_a: assert property (
    BUS_REQ.rd && BUS_REQ.addr == OFS_EVT_EN |=>
      BUS_RDATA == {30'h0, $past(evt_enable)})
    else $error("Enable read word wrong");

  // ----------------------------------------------------------------
  // Assertions: event flags and interrupt
  // ----------------------------------------------------------------

  // Every finished reception is flagged, even against a clear
  rx_evt_a: assert property (
    RX_DONE |=> evt_status[EVT_RX_DONE])
    else $error("Reception not flagged");

  crc_ok_quiet_a: assert property ( // RULE1
    RX_DONE && RX_RESULT.crc_passed &&
      !evt_status[EVT_CRC_FAIL] |=> !evt_status[EVT_CRC_FAIL])
    else $error("Passing CRC raised the failure flag");

  flag_clear_a: assert property (
    clr_wr && !RX_DONE |=>
      (evt_status & $past(BUS_REQ.wdata[EVT_N-1:0])) == '0)
    else $error("Written ones did not clear flags");

  flag_hold_a: assert property (
    !RX_DONE && !clr_wr |=> $stable(evt_status))
    else $error("Flags changed with no event or clear");

  en_write_a: assert property (
    en_wr |=> evt_enable == $past(BUS_REQ.wdata[EVT_N-1:0]))
    else $error("Enable mask not written");

  // Without this the interrupt could stick after a clear
  irq_quiet_a: assert property (
    !(|(evt_status & evt_enable)) |=> !IRQ)
    else $error("Interrupt with no enabled flag");

endmodule : rsr_rx_status

`default_nettype wire

// [src/rsr_pkg.sv]
// Constants and types for the receive status register bank.
// Assumes one synchronous clock domain shared with the bus master.
//
// Functional notes
// RULE1: CRC result bit: 0 failed, 1 passed.
// RULE2: Three-bit logical address of last packet.
// RULE3: Received CRC field in low 24 bits.
// RULE4: Index of matching device address entry.
// RULE5: Tone extension: duration, reserved bit, type.
// RULE6: Antenna switch state code, idle 0..ending 5.
// RULE7: Sampling state bit: 0 idle, 1 sampling.
// RULE8: Fields update on reception done, else hold.
`default_nettype none

package rsr_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] OFS_CRC_RES   = 12'h400;
  localparam logic [11:0] OFS_LADDR     = 12'h408;
  localparam logic [11:0] OFS_RECEIVED_CRC_VALUE     = 12'h40c;
  localparam logic [11:0] OFS_DAI       = 12'h410;
  localparam logic [11:0] OFS_PSTAT     = 12'h414;
  localparam logic [11:0] OFS_TE_INFO   = 12'h44c;
  localparam logic [11:0] OFS_DF_STATE  = 12'h458;
  localparam logic [11:0] OFS_EVT_STAT  = 12'h480;
  localparam logic [11:0] OFS_EVT_EN    = 12'h484;
  localparam logic [11:0] OFS_EVT_CLR   = 12'h488;

  // ----------------------------------------------------------------
  // Field positions, widths and reset values
  // ----------------------------------------------------------------
  localparam int          TE_DUR_LSB    = 0;
  localparam int          TE_RSV_BIT    = 5;
  localparam int          TE_TYPE_LSB   = 6;
  localparam int          DF_SAMP_BIT   = 3;
  localparam logic [31:0] RESET_WORD    = 32'h0000_0000;
  localparam int          EVT_N         = 2;
  localparam int          EVT_RX_DONE   = 0;
  localparam int          EVT_CRC_FAIL  = 1;

  // Antenna switching state codes as reported
  typedef enum logic [2:0] {
    SW_IDLE   = 3'h0,
    SW_OFFSET = 3'h1,
    SW_GUARD  = 3'h2,
    SW_REF    = 3'h3,
    SW_SWITCH = 3'h4,
    SW_ENDING = 3'h5
  } rsr_switch_state_type;

  // Tone extension header as parsed from the packet
  typedef struct packed {
    logic [1:0] tone_extension_type;
    logic       reserved_bit;
    logic [4:0] tone_extension_duration;
  } rsr_te_header_type;

  // Results of one completed reception
  typedef struct packed {
    logic              crc_passed;
    logic [2:0]        logical_address;
    logic [23:0]       crc_value;
    logic [2:0]        match_index;
    logic [1:0]        payload_status;
    rsr_te_header_type te_header;
  } rsr_rx_result_type;

  // Live direction-finding engine state
  typedef struct packed {
    rsr_switch_state_type antenna_switch_state;
    logic                 sample_capture_state;
  } rsr_df_state_type;

  // One register access from the master
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } rsr_bus_req_type;

endpackage : rsr_pkg

`default_nettype wire

// [src/rsr_event_flags.sv]
// Sticky event flags with enable mask and a level interrupt.
// Assumes set pulses and clear writes share the one clock.
`default_nettype none

module rsr_event_flags #(
  parameter int N = 2
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [N-1:0] set_evt,
  input  wire logic         clr_wr,
  input  wire logic         en_wr,
  input  wire logic [N-1:0] wdata,
  output var  logic [N-1:0] status_reg,
  output var  logic [N-1:0] enable_reg,
  output var  logic         irq_reg
);

  // Refuse widths that the bus word cannot hold
  if (N < 1 || N > 32) begin : g_bad_n
    $error("N must be 1 to 32");
  end

  // ----------------------------------------------------------------
  // Flags: set wins over a clear in the same cycle
  // ----------------------------------------------------------------
  for (genvar i = 0; i < N; i++) begin : g_flag
    always_ff @(posedge clk) begin
      if (rst) begin
        status_reg[i] <= 1'b0;
      end else if (set_evt[i]) begin
        status_reg[i] <= 1'b1;
      end else if (clr_wr && wdata[i]) begin
        status_reg[i] <= 1'b0;
      end
    end
  end

  // Enable mask, written whole
  always_ff @(posedge clk) begin
    if (rst) begin
      enable_reg <= '0;
    end else if (en_wr) begin
      enable_reg <= wdata;
    end
  end

  // Interrupt level lags the flags by one cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_reg & enable_reg);
    end
  end

endmodule : rsr_event_flags

`default_nettype wire

// [dv/tb_rsr_rx_status.sv]
// Self-checking testbench for the receive status register bank.
// Assumes rsr_pkg and rsr_rx_status are compiled before this file.
`default_nettype none

module tb_rsr_rx_status;
  timeunit 1ns;
  timeprecision 1ps;
  import rsr_pkg::*;

  logic              sys_clk;
  logic              sys_rst;
  rsr_bus_req_type   bus_req;
  logic [31:0]       bus_rdata;
  logic              rx_done;
  rsr_rx_result_type rx_result;
  rsr_df_state_type  df_state;
  logic              irq;
  int                n_errors = 0;
  int                n_tests  = 0;
  int                cycles   = 0;

  rsr_rx_status i_dut (
    .SYS_CLK   (sys_clk),
    .SYS_RST   (sys_rst),
    .BUS_REQ   (bus_req),
    .BUS_RDATA (bus_rdata),
    .RX_DONE   (rx_done),
    .RX_RESULT (rx_result),
    .DF_STATE  (df_state),
    .IRQ       (irq)
  );

  // ------------------------------------------------------------
  // Clock and hang guard
  // ------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // The run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors = n_errors + 1;
      tally_and_finish();
    end
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    bus_req.addr <= a;
    bus_req.rd   <= 1'b1;
    @(posedge sys_clk);
    bus_req.rd   <= 1'b0;
    #1;
    chk(bus_rdata, exp);
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    bus_req.wr    <= 1'b1;
    @(posedge sys_clk);
    bus_req.wr    <= 1'b0;
  endtask : wr

  // Result is scrambled after the pulse so a missing hold shows
  task automatic rx(input rsr_rx_result_type r);
    @(posedge sys_clk);
    rx_result <= r;
    rx_done   <= 1'b1;
    @(posedge sys_clk);
    rx_done   <= 1'b0;
    rx_result <= ~r;
  endtask : rx

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    logic [11:0] ofs [9];
    ofs = '{OFS_CRC_RES, OFS_LADDR, OFS_RECEIVED_CRC_VALUE, OFS_DAI, OFS_PSTAT,
            OFS_TE_INFO, OFS_DF_STATE, OFS_EVT_STAT, OFS_EVT_EN};
    @(posedge sys_clk);
    sys_rst  <= 1'b1;
    df_state <= '0;
    repeat (8) @(posedge sys_clk);
    sys_rst  <= 1'b0;
    foreach (ofs[i]) rd(ofs[i], RESET_WORD);
    chk({31'h0, irq}, 32'h0);
  endtask : t_reset

  task automatic t_capture;
    rx('{1'b1, 3'h5, 24'ha5c35a, 3'h6, 2'h2, '{2'h3, 1'b1, 5'h15}});
    rd(OFS_CRC_RES, 32'h1);
    rd(OFS_LADDR, 32'h5);
    rd(OFS_RECEIVED_CRC_VALUE, 32'h00a5c35a);
    rd(OFS_DAI, 32'h6);
    rd(OFS_PSTAT, 32'h2);
    rd(OFS_TE_INFO, 32'hf5);
    wr(OFS_RECEIVED_CRC_VALUE, 32'hffffffff);
    rd(OFS_RECEIVED_CRC_VALUE, 32'h00a5c35a);
    rd(12'h404, 32'h0);
    rd(OFS_EVT_CLR, 32'h0);
    rx('{1'b0, 3'h2, 24'h000001, 3'h1, 2'h1, '{2'h1, 1'b0, 5'h0a}});
    rd(OFS_CRC_RES, 32'h0);
    rd(OFS_LADDR, 32'h2);
    rd(OFS_RECEIVED_CRC_VALUE, 32'h1);
    rd(OFS_TE_INFO, 32'h4a);
  endtask : t_capture

  // A read in the capture cycle sees the old word, the next the new
  task automatic t_overlap;
    @(posedge sys_clk);
    rx_result    <= '{1'b1, 3'h3, 24'h5a5a5a, 3'h2, 2'h1, '0};
    rx_done      <= 1'b1;
    bus_req.addr <= OFS_CRC_RES;
    bus_req.rd   <= 1'b1;
    @(posedge sys_clk);
    rx_done      <= 1'b0;
    rx_result    <= '0;
    bus_req.addr <= OFS_RECEIVED_CRC_VALUE;
    #1;
    chk(bus_rdata, 32'h0);
    @(posedge sys_clk);
    bus_req.rd   <= 1'b0;
    #1;
    chk(bus_rdata, 32'h005a5a5a);
    rd(OFS_CRC_RES, 32'h1);
  endtask : t_overlap

  task automatic t_df;
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk);
      df_state <= '{rsr_switch_state_type'(i[2:0]), i[0]};
      rd(OFS_DF_STATE, {28'h0, i[0], i[2:0]});
    end
    @(posedge sys_clk);
    df_state <= '{SW_IDLE, 1'b1};
    rd(OFS_DF_STATE, 32'h8);
  endtask : t_df

  task automatic t_irq;
    wr(OFS_EVT_CLR, 32'h3);
    rd(OFS_EVT_STAT, 32'h0);
    wr(OFS_EVT_EN, 32'h3);
    rd(OFS_EVT_EN, 32'h3);
    rx('{1'b0, 3'h1, 24'h0, 3'h0, 2'h0, '0});
    rd(OFS_EVT_STAT, 32'h3);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_EVT_CLR, 32'h1);
    rd(OFS_EVT_STAT, 32'h2);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_EVT_CLR, 32'h2);
    rd(OFS_EVT_STAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // Masked event still latches but must stay quiet
    wr(OFS_EVT_EN, 32'h0);
    rx('{1'b1, 3'h1, 24'h0, 3'h0, 2'h0, '0});
    rd(OFS_EVT_STAT, 32'h1);
    chk({31'h0, irq}, 32'h0);
  endtask : t_irq

  // ------------------------------------------------------------
  // Main sequence and verdict
  // ------------------------------------------------------------
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    sys_rst   = 1'b1;
    bus_req   = '0;
    rx_done   = 1'b0;
    rx_result = '0;
    df_state  = '0;
    t_reset();
    t_capture();
    t_overlap();
    t_df();
    t_irq();
    t_reset();
    tally_and_finish();
  end

endmodule : tb_rsr_rx_status

`default_nettype wire
